/* viop_cfg.svh */
// Constants for the video image output port: offsets, fields, reset values and codes.
`ifndef VIOP_CFG_SVH
`define VIOP_CFG_SVH
`define VIOP_REG_CTRL 8'h00
`define VIOP_REG_REFS 8'h04
`define VIOP_REG_STAT 8'h08
`define VIOP_REG_ANC 8'h0C
`define VIOP_CTRL_RST 32'h0000_1231
`define VIOP_REFS_RST 32'h0000_0000
`define VIOP_ANC_RST 32'h0000_0055
`define VIOP_CTRL_EMBED 0
`define VIOP_CTRL_WIDE 1
`define VIOP_CTRL_SWAP 3:2
`define VIOP_CTRL_OE_DATA 4
`define VIOP_CTRL_OE_REFS 5
`define VIOP_CTRL_CKS 7:6
`define VIOP_CTRL_GATED 8
`define VIOP_CTRL_QPOL 9
`define VIOP_CTRL_RECODE 10
`define VIOP_CTRL_LIMIT 11
`define VIOP_CTRL_PRIO 12
`define VIOP_REFS_HFUNC 1:0
`define VIOP_REFS_HPOL 2
`define VIOP_REFS_VFUNC 4:3
`define VIOP_REFS_VPOL 5
`define VIOP_REFS_G1FUNC 7:6
`define VIOP_REFS_G1POL 9
`define VIOP_REFS_G0FUNC 11:10
`define VIOP_REFS_G0POL 13
`define VIOP_CKS_INPUT 2'h0
`define VIOP_CKS_LLC 2'h1
`define VIOP_CKS_EXPANSION_PORT_CLOCK 2'h2
`define VIOP_FN_GATE 2'h0
`define VIOP_FN_PULSE 2'h1
`define VIOP_GP_FIELD 2'h0
`define VIOP_GP_VBI 2'h1
`define VIOP_GP_NONEMPTY 2'h2
`define VIOP_GP_LINE 2'h3
`define VIOP_BYTE_FILL 8'h00
`define VIOP_BYTE_ONES 8'hFF
`define VIOP_CLIP_LO 8'h01
`define VIOP_CLIP_HI 8'hFE
`define VIOP_LIMIT_LO 8'h10
`define VIOP_LIMIT_HI 8'hF0
`define VIOP_RECODE_LO 8'h03
`define VIOP_RECODE_HI 8'hFC
`define VIOP_FIFO_AW 6
`define VIOP_FIFO_DEPTH 64
`define VIOP_ANC_LAST 3'h5
`endif

/* viop_pkg.sv */
// Types shared by the video image output port.
package viop_pkg;
    typedef enum logic [2:0] {
        VIOP_IDLE = 3'h0,
        VIOP_VCODE = 3'h1,
        VIOP_VDATA = 3'h3,
        VIOP_AHDR = 3'h2,
        VIOP_ADATA = 3'h6
    } viop_state_t;
    typedef enum logic [1:0] {
        VIOP_K_FILL = 2'h0,
        VIOP_K_CODE = 2'h1,
        VIOP_K_VID = 2'h2,
        VIOP_K_ANC = 2'h3
    } viop_kind_t;
    typedef struct packed {
        logic sol;
        logic eol;
        logic raw;
        logic [31:0] data;
    } viop_word_t;
    typedef struct packed {
        viop_kind_t kind;
        logic valid;
        logic [7:0] data;
        logic [7:0] ext;
    } viop_out_t;
endpackage

/* viop_port.sv */
// Video image output port: arbiter, code inserter, serializer, VBI FIFO and reference outputs.
//
// Notes on behaviour
// - Each 32-bit word of four bytes leaves as four bytes or two 16-bit words.
// - In 16-bit mode chroma bytes go out on the extension bus.
// - Sliced VBI bytes of a line, up to 64 per block, are buffered, then sent as one block.
// - Scaled video and sliced VBI are arbitrated; VBI wins by default.
// - With embedded codes eight data lines plus one clock suffice.
// - Start and end codes surround only lines that carry data.
// - Filler bytes of zero may appear, but never inside a four-byte code.
// - Raw VBI sample lines are wrapped in codes like video lines.
// - Direct ancillary mode passes VBI bytes unchanged, zeros and ones included.
// - Recoded ancillary mode turns 00H into 03H and FFH into FCH.
// - No filler cycles inside an ancillary header or data field.
// - Video and raw VBI bytes clip 00H to 01H and FFH to FEH.
// - An option limits the output sample range further.
// - Reference clock is input or output; as output from line-locked or expansion clock.
// - Data-valid qualifier has programmable polarity or acts as gated clock.
// - Horizontal reference mirrors the horizontal gate or gives a reset pulse.
// - Vertical reference mirrors the vertical gate or gives a reset pulse.
// - Field, gates and FIFO flags are offered on the reference and general outputs.
// - Either general output can flag sliced VBI data.
// - The tristate control input turns off every port output.
// - Reset pulses start at the rising edge of the active-high gate.
// - Cycles without valid data carry byte zero and an inactive qualifier.
// - Gated clock mode outputs reference clock AND internal data-valid.
//
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "viop_cfg.svh"
module viop_port
    import viop_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire viop_word_t vid_word,
    input wire logic vid_valid,
    output logic vid_ready,
    input wire logic [7:0] vbi_byte,
    input wire logic vbi_last,
    input wire logic vbi_valid,
    output logic vbi_ready,
    input wire logic scaler_h_gate,
    input wire logic scaler_v_gate,
    input wire logic scaler_field,
    input wire logic line_locked_clock,
    input wire logic expansion_port_clock,
    input wire logic port_ref_clock_i,
    output logic port_ref_clock_o,
    output logic port_ref_clock_oe,
    input wire logic tristate_ctrl_in,
    input wire logic target_ready_in,
    output logic [7:0] port_data_bus_o,
    output logic port_data_bus_oe,
    output logic [7:0] chroma_extension_bus_o,
    output logic chroma_extension_bus_oe,
    output logic data_valid_qualifier,
    output logic horiz_ref_out,
    output logic vert_ref_out,
    output logic gp_out_zero,
    output logic gp_out_one,
    output logic ctrl_outputs_oe
);
    // ==========================================================
    // Register file.
    logic [31:0] ctrl_q, ctrl_d, refs_q, refs_d, anc_q, anc_d, rdata_q, rdata_d;
    viop_state_t st_q, st_d;
    logic [6:0] fcnt_q;
    logic line_rdy_q;
    logic hold_v_q;

    always_comb begin
        ctrl_d = ctrl_q;
        refs_d = refs_q;
        anc_d = anc_q;
        rdata_d = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                `VIOP_REG_CTRL: ctrl_d = reg_wdata;
                `VIOP_REG_REFS: refs_d = reg_wdata;
                `VIOP_REG_ANC: anc_d = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `VIOP_REG_CTRL: rdata_d = ctrl_q;
                `VIOP_REG_REFS: rdata_d = refs_q;
                `VIOP_REG_ANC: rdata_d = anc_q;
                `VIOP_REG_STAT: rdata_d = {20'h0_0000, hold_v_q, line_rdy_q, fcnt_q, st_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `VIOP_CTRL_RST;
            refs_q <= `VIOP_REFS_RST;
            anc_q <= `VIOP_ANC_RST;
            rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            refs_q <= refs_d;
            anc_q <= anc_d;
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata = rdata_q;

    // ==========================================================
    // Pin synchronisers and reference clock.
    logic [4:0] pins_s1_q, pins_s2_q;
    logic ref_out_q, ref_out_d, ref_prev_q, ref_now, tick, tri_s, trdy_s;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_s1_q <= 5'h00;
            pins_s2_q <= 5'h00;
        end else begin
            pins_s1_q <= {target_ready_in, tristate_ctrl_in, expansion_port_clock,
                line_locked_clock, port_ref_clock_i};
            pins_s2_q <= pins_s1_q;
        end
    end
    assign tri_s = pins_s2_q[3];
    assign trdy_s = pins_s2_q[4];

    always_comb begin
        ref_out_d = (ctrl_q[`VIOP_CTRL_CKS] == `VIOP_CKS_EXPANSION_PORT_CLOCK) ? pins_s2_q[2] : pins_s2_q[1];
        ref_now = (ctrl_q[`VIOP_CTRL_CKS] == `VIOP_CKS_INPUT) ? pins_s2_q[0] : ref_out_q;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_out_q <= 1'b0;
            ref_prev_q <= 1'b0;
        end else begin
            ref_out_q <= ref_out_d;
            ref_prev_q <= ref_now;
        end
    end
    assign tick = ref_now && !ref_prev_q;
    assign port_ref_clock_o = ref_out_q;

    // ==========================================================
    // Sliced VBI line FIFO.
    logic [7:0] fifo_mem [`VIOP_FIFO_DEPTH];
    logic [`VIOP_FIFO_AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
    logic [6:0] fcnt_d;
    logic line_rdy_d, fifo_push, fifo_pop, line_take;

    assign vbi_ready = !line_rdy_q && (fcnt_q != 7'(`VIOP_FIFO_DEPTH));
    assign fifo_push = vbi_valid && vbi_ready;

    always_comb begin
        wptr_d = fifo_push ? wptr_q + 1'b1 : wptr_q;
        rptr_d = fifo_pop ? rptr_q + 1'b1 : rptr_q;
        fcnt_d = fcnt_q + 7'(fifo_push) - 7'(fifo_pop);
        line_rdy_d = line_rdy_q;
        if (line_take) begin
            line_rdy_d = 1'b0;
        end
        if (fifo_push && (vbi_last || fcnt_q == 7'(`VIOP_FIFO_DEPTH - 1))) begin
            line_rdy_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (fifo_push) begin
            fifo_mem[wptr_q] <= vbi_byte;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr_q <= '0;
            rptr_q <= '0;
            fcnt_q <= 7'h00;
            line_rdy_q <= 1'b0;
        end else begin
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            fcnt_q <= fcnt_d;
            line_rdy_q <= line_rdy_d;
        end
    end

    // ==========================================================
    // Arbiter, code inserter and serializer.
    viop_word_t hold_q, hold_d;
    logic hold_v_d, eav_q, eav_d, raw_q, raw_d, hold_take;
    logic [2:0] idx_q, idx_d;
    logic [6:0] left_q, left_d;
    logic [7:0] xy, vb, ab;
    logic [1:0] lane;
    viop_out_t out_q, out_d;
    logic wide, embed;

    assign wide = ctrl_q[`VIOP_CTRL_WIDE];
    assign embed = ctrl_q[`VIOP_CTRL_EMBED];
    assign vid_ready = !hold_v_q;

    function automatic logic [7:0] clip_byte(input logic [7:0] b, input logic lim);
        clip_byte = lim ? ((b < `VIOP_LIMIT_LO) ? `VIOP_LIMIT_LO :
            (b > `VIOP_LIMIT_HI) ? `VIOP_LIMIT_HI : b) :
            ((b == `VIOP_BYTE_FILL) ? `VIOP_CLIP_LO : (b == `VIOP_BYTE_ONES) ? `VIOP_CLIP_HI : b);
    endfunction

    always_comb begin
        xy = {1'b1, scaler_field, raw_q | !scaler_v_gate, eav_q, 4'h0};
        xy[3:0] = {xy[5] ^ xy[4], xy[6] ^ xy[4], xy[6] ^ xy[5], xy[6] ^ xy[5] ^ xy[4]};
        lane = wide ? {idx_q[0], 1'b1} : idx_q[1:0] ^ ctrl_q[`VIOP_CTRL_SWAP];
        vb = clip_byte(hold_q.data[8*lane +: 8], ctrl_q[`VIOP_CTRL_LIMIT]);
        ab = fifo_mem[rptr_q];
        if (ctrl_q[`VIOP_CTRL_RECODE]) begin
            ab = (ab == `VIOP_BYTE_FILL) ? `VIOP_RECODE_LO : (ab == `VIOP_BYTE_ONES) ? `VIOP_RECODE_HI : ab;
        end
    end

    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        eav_d = eav_q;
        raw_d = raw_q;
        left_d = left_q;
        hold_take = 1'b0;
        fifo_pop = 1'b0;
        line_take = 1'b0;
        out_d = out_q;
        if (tick) begin
            out_d = '{kind: VIOP_K_FILL, valid: 1'b0, data: `VIOP_BYTE_FILL, ext: `VIOP_BYTE_FILL};
            unique case (st_q)
                VIOP_IDLE: begin
                    if (trdy_s && line_rdy_q &&
                        (ctrl_q[`VIOP_CTRL_PRIO] || !(hold_v_q && hold_q.sol))) begin
                        left_d = fcnt_q;
                        idx_d = 3'h0;
                        st_d = embed ? VIOP_AHDR : VIOP_ADATA;
                    end else if (trdy_s && hold_v_q && hold_q.sol) begin
                        raw_d = hold_q.raw;
                        eav_d = 1'b0;
                        idx_d = 3'h0;
                        st_d = embed ? VIOP_VCODE : VIOP_VDATA;
                    end else if (hold_v_q && !hold_q.sol) begin
                        hold_take = 1'b1;
                    end
                end
                VIOP_VCODE: begin
                    out_d.kind = VIOP_K_CODE;
                    out_d.valid = 1'b1;
                    out_d.data = (idx_q == 3'h3) ? xy :
                        (idx_q == 3'h0) ? `VIOP_BYTE_ONES : `VIOP_BYTE_FILL;
                    out_d.ext = out_d.data;
                    idx_d = idx_q + 3'h1;
                    if (idx_q == 3'h3) begin
                        idx_d = 3'h0;
                        st_d = eav_q ? VIOP_IDLE : VIOP_VDATA;
                    end
                end
                VIOP_VDATA: begin
                    if (hold_v_q && trdy_s) begin
                        out_d.kind = VIOP_K_VID;
                        out_d.valid = 1'b1;
                        out_d.data = vb;
                        if (wide) begin
                            out_d.ext = clip_byte(hold_q.data[8*{idx_q[0], 1'b0} +: 8],
                                ctrl_q[`VIOP_CTRL_LIMIT]);
                        end
                        idx_d = idx_q + 3'h1;
                        if (idx_q == (wide ? 3'h1 : 3'h3)) begin
                            idx_d = 3'h0;
                            hold_take = 1'b1;
                            if (hold_q.eol) begin
                                eav_d = 1'b1;
                                st_d = embed ? VIOP_VCODE : VIOP_IDLE;
                            end
                        end
                    end
                end
                VIOP_AHDR: begin
                    out_d.kind = VIOP_K_CODE;
                    out_d.valid = 1'b1;
                    unique case (idx_q)
                        3'h0: out_d.data = `VIOP_BYTE_FILL;
                        3'h1, 3'h2: out_d.data = `VIOP_BYTE_ONES;
                        3'h3: out_d.data = anc_q[7:0];
                        3'h4: out_d.data = {7'h00, scaler_field};
                        default: out_d.data = {1'b0, left_q};
                    endcase
                    idx_d = idx_q + 3'h1;
                    if (idx_q == `VIOP_ANC_LAST) begin
                        st_d = VIOP_ADATA;
                    end
                end
                VIOP_ADATA: begin
                    out_d.kind = VIOP_K_ANC;
                    out_d.valid = 1'b1;
                    out_d.data = ab;
                    fifo_pop = 1'b1;
                    left_d = left_q - 7'h01;
                    if (left_q == 7'h01) begin
                        line_take = 1'b1;
                        st_d = VIOP_IDLE;
                    end
                end
                default: st_d = VIOP_IDLE;
            endcase
        end
        hold_v_d = hold_take ? 1'b0 : hold_v_q;
        hold_d = hold_q;
        if (vid_valid && vid_ready) begin
            hold_v_d = 1'b1;
            hold_d = vid_word;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= VIOP_IDLE;
            idx_q <= 3'h0;
            eav_q <= 1'b0;
            raw_q <= 1'b0;
            left_q <= 7'h00;
            hold_v_q <= 1'b0;
            hold_q <= '0;
            out_q <= '0;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            eav_q <= eav_d;
            raw_q <= raw_d;
            left_q <= left_d;
            hold_v_q <= hold_v_d;
            hold_q <= hold_d;
            out_q <= out_d;
        end
    end

    // ==========================================================
    // Reference and general outputs.
    logic hg_prev_q, vg_prev_q, hpls_q, hpls_d, vpls_q, vpls_d, vbi_on;
    logic [3:0] refo_q, refo_d;

    function automatic logic gp_sel(input logic [1:0] fn, input logic f, input logic v,
        input logic ne, input logic ln);
        gp_sel = (fn == `VIOP_GP_FIELD) ? f : (fn == `VIOP_GP_VBI) ? v :
            (fn == `VIOP_GP_NONEMPTY) ? ne : ln;
    endfunction

    always_comb begin
        hpls_d = hpls_q && !tick;
        vpls_d = vpls_q && !tick;
        if (scaler_h_gate && !hg_prev_q) begin
            hpls_d = 1'b1;
        end
        if (scaler_v_gate && !vg_prev_q) begin
            vpls_d = 1'b1;
        end
        vbi_on = (st_q == VIOP_AHDR) || (st_q == VIOP_ADATA);
        refo_d[0] = refs_q[`VIOP_REFS_HPOL] ^
            ((refs_q[`VIOP_REFS_HFUNC] == `VIOP_FN_PULSE) ? hpls_q : scaler_h_gate);
        refo_d[1] = refs_q[`VIOP_REFS_VPOL] ^
            ((refs_q[`VIOP_REFS_VFUNC] == `VIOP_FN_PULSE) ? vpls_q : scaler_v_gate);
        refo_d[2] = refs_q[`VIOP_REFS_G0POL] ^ gp_sel(refs_q[`VIOP_REFS_G0FUNC],
            scaler_field, vbi_on, fcnt_q != 7'h00, line_rdy_q);
        refo_d[3] = refs_q[`VIOP_REFS_G1POL] ^ gp_sel(refs_q[`VIOP_REFS_G1FUNC],
            scaler_field, vbi_on, fcnt_q != 7'h00, line_rdy_q);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hg_prev_q <= 1'b0;
            vg_prev_q <= 1'b0;
            hpls_q <= 1'b0;
            vpls_q <= 1'b0;
            refo_q <= 4'h0;
        end else begin
            hg_prev_q <= scaler_h_gate;
            vg_prev_q <= scaler_v_gate;
            hpls_q <= hpls_d;
            vpls_q <= vpls_d;
            refo_q <= refo_d;
        end
    end

    // ==========================================================
    // Pin drivers.
    assign horiz_ref_out = refo_q[0];
    assign vert_ref_out = refo_q[1];
    assign gp_out_zero = refo_q[2];
    assign gp_out_one = refo_q[3];
    assign port_data_bus_o = out_q.data;
    assign chroma_extension_bus_o = out_q.ext;
    assign data_valid_qualifier = ctrl_q[`VIOP_CTRL_GATED] ? (ref_now && out_q.valid) :
        (out_q.valid ~^ ctrl_q[`VIOP_CTRL_QPOL]);
    assign port_data_bus_oe = ctrl_q[`VIOP_CTRL_OE_DATA] && !tri_s;
    assign chroma_extension_bus_oe = port_data_bus_oe && wide;
    assign ctrl_outputs_oe = ctrl_q[`VIOP_CTRL_OE_REFS] && !tri_s;
    assign port_ref_clock_oe = ctrl_outputs_oe && (ctrl_q[`VIOP_CTRL_CKS] != `VIOP_CKS_INPUT);

    // ==========================================================
    // Assertions.
    a_fill_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !out_q.valid |-> out_q.data == `VIOP_BYTE_FILL) else $error("filler byte not zero");
    a_video_clip: assert property (@(posedge clk) disable iff (!rst_n)
        out_q.kind == VIOP_K_VID |-> out_q.data != 8'h00 && out_q.data != 8'hFF)
        else $error("video byte not clipped");
    a_code_no_gap: assert property (@(posedge clk) disable iff (!rst_n)
        tick && st_q == VIOP_VCODE |=> out_q.valid && out_q.kind == VIOP_K_CODE)
        else $error("gap inside timing code");
    a_anc_no_gap: assert property (@(posedge clk) disable iff (!rst_n)
        tick && st_q == VIOP_ADATA |=> out_q.valid && $stable(st_q) || st_q == VIOP_IDLE)
        else $error("gap inside ancillary block");
    a_anc_recode: assert property (@(posedge clk) disable iff (!rst_n)
        tick && st_q == VIOP_ADATA && ctrl_q[`VIOP_CTRL_RECODE] |=>
        out_q.data != 8'h00 && out_q.data != 8'hFF) else $error("ancillary byte not recoded");
    a_vbi_first: assert property (@(posedge clk) disable iff (!rst_n)
        tick && st_q == VIOP_IDLE && trdy_s && line_rdy_q && ctrl_q[`VIOP_CTRL_PRIO] |=>
        st_q == VIOP_AHDR || st_q == VIOP_ADATA) else $error("slicer lost arbitration");
    a_tri_off: assert property (@(posedge clk) disable iff (!rst_n)
        tri_s |-> !port_data_bus_oe && !chroma_extension_bus_oe && !ctrl_outputs_oe
        && !port_ref_clock_oe) else $error("output driven in tristate");
    a_hpulse_rise: assert property (@(posedge clk) disable iff (!rst_n)
        scaler_h_gate && !hg_prev_q && refs_q[`VIOP_REFS_HFUNC] == `VIOP_FN_PULSE
        && !refs_q[`VIOP_REFS_HPOL] |=> ##1 horiz_ref_out) else $error("missing horizontal pulse");
    a_fifo_block: assert property (@(posedge clk) disable iff (!rst_n)
        st_q == VIOP_ADATA |-> fcnt_q != 7'h00 && !vbi_ready) else $error("vbi block broken");
    a_gated_clk: assert property (@(posedge clk) disable iff (!rst_n)
        ctrl_q[`VIOP_CTRL_GATED] && !out_q.valid |-> !data_valid_qualifier)
        else $error("gated clock leaks");
endmodule

/* viop_rx_model.sv */
// Receiver model that clocks the video image output port and captures its bytes.
`timescale 1ns/1ns
module viop_rx_model (
    input wire logic [7:0] port_data_bus_o,
    input wire logic data_valid_qualifier,
    input wire logic slow,
    output logic port_ref_clock_i,
    output logic target_ready_in,
    output logic [7:0] rx_byte,
    output int rx_cnt
);
    initial begin
        port_ref_clock_i = 1'b0;
        target_ready_in = 1'b1;
        rx_byte = 8'h00;
        rx_cnt = 0;
    end
    // The reference clock runs free.
    always #16 port_ref_clock_i = ~port_ref_clock_i;
    // Bytes are taken mid-period and only while the qualifier is active.
    always @(negedge port_ref_clock_i) begin
        if (data_valid_qualifier === 1'b1) begin
            rx_byte = port_data_bus_o;
            rx_cnt = rx_cnt + 1;
        end
        target_ready_in = slow ? ~target_ready_in : 1'b1;
    end
endmodule

/* tb.sv */
// Self-checking testbench for the video image output port.
`timescale 1ns/1ns
`include "viop_cfg.svh"
module tb;
    import viop_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    viop_word_t vid_word = '0;
    logic vid_valid = 1'b0;
    logic vid_ready;
    logic [7:0] vbi_byte = 8'h00;
    logic vbi_last = 1'b0;
    logic vbi_valid = 1'b0;
    logic vbi_ready;
    logic h_gate = 1'b0;
    logic field = 1'b0;
    logic tri_in = 1'b0;
    logic slow = 1'b0;
    logic rec = 1'b0;
    logic v_gate = 1'b1;
    int wide16 = 0;
    logic refclk, trdy, data_oe, ctrl_oe, qual, h_out, ext_oe, v_out, gp0;
    logic [7:0] data_o, rx_byte, did, ext_o;
    int rx_cnt;
    int n_errors = 0;
    int cmp_count = 0;
    int seed = 32'h85dfcda9;
    logic [7:0] exp_q [$], ext_q [$];
    always #2 clk = ~clk;
    viop_port dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .vid_word(vid_word),
        .vid_valid(vid_valid), .vid_ready(vid_ready), .vbi_byte(vbi_byte), .vbi_last(vbi_last),
        .vbi_valid(vbi_valid), .vbi_ready(vbi_ready), .scaler_h_gate(h_gate),
        .scaler_v_gate(v_gate), .scaler_field(field), .line_locked_clock(refclk),
        .expansion_port_clock(1'b0), .port_ref_clock_i(refclk), .port_ref_clock_o(),
        .port_ref_clock_oe(), .tristate_ctrl_in(tri_in), .target_ready_in(trdy),
        .port_data_bus_o(data_o), .port_data_bus_oe(data_oe), .chroma_extension_bus_o(ext_o),
        .chroma_extension_bus_oe(ext_oe), .data_valid_qualifier(qual), .horiz_ref_out(h_out),
        .vert_ref_out(v_out), .gp_out_zero(gp0), .gp_out_one(), .ctrl_outputs_oe(ctrl_oe));
    viop_rx_model rx_u (.port_data_bus_o(data_o), .data_valid_qualifier(qual), .slow(slow),
        .port_ref_clock_i(refclk), .target_ready_in(trdy), .rx_byte(rx_byte), .rx_cnt(rx_cnt));
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            n_errors++;
        end
    endtask
    function automatic logic [7:0] xy(input logic f, input logic v, input logic h);
        return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
    endfunction
    function automatic logic [7:0] clip(input logic [7:0] b);
        return (b == 8'h00) ? 8'h01 : ((b == 8'hFF) ? 8'hFE : b);
    endfunction
    task automatic put(input logic [7:0] m, input logic [7:0] e);
        exp_q.push_back(m);
        if (wide16) ext_q.push_back(e);
    endtask
    task automatic push_code(input logic f, input logic v, input logic h);
        put(8'hFF, 8'hFF);
        put(8'h00, 8'h00);
        put(8'h00, 8'h00);
        put(xy(f, v, h), xy(f, v, h));
    endtask
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check("reg_rdata", e, reg_rdata);
        @(posedge clk);
    endtask
    task automatic drain(input string name);
        for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge clk);
        check("pending_bytes", 0, exp_q.size());
        check("pending_ext", 0, ext_q.size());
        $display("test %s done", name);
    endtask
    task automatic vid_line(input logic raw, input logic f);
        logic [31:0] d [2];
        d[0] = 32'hFF00_8040;
        d[1] = $random(seed);
        field <= f;
        @(posedge clk);
        push_code(f, raw | !v_gate, 1'b0);
        for (int i = 0; i < 2; i++)
            for (int k = wide16; k < 4; k += 1 + wide16)
                put(clip(d[i][8*k+:8]), clip(d[i][8*(k|1)-8+:8]));
        push_code(f, raw | !v_gate, 1'b1);
        for (int i = 0; i < 2; i++) begin
            vid_word <= '{sol: i == 0, eol: i == 1, raw: raw, data: d[i]};
            vid_valid <= 1'b1;
            do @(posedge clk); while (vid_ready !== 1'b1);
        end
        vid_valid <= 1'b0;
        drain("video line");
    endtask
    task automatic vbi_line(input logic [7:0] b2);
        logic [7:0] v [3];
        v = '{8'h00, 8'hFF, b2};
        exp_q = '{8'h00, 8'hFF, 8'hFF, did, {7'h00, field}, 8'h03};
        for (int i = 0; i < 3; i++) begin
            exp_q.push_back(rec ? ((v[i] == 8'h00) ? 8'h03 : ((v[i] == 8'hFF) ? 8'hFC : v[i])) : v[i]);
            vbi_byte <= v[i];
            vbi_last <= (i == 2);
            vbi_valid <= 1'b1;
            do @(posedge clk); while (vbi_ready !== 1'b1);
        end
        vbi_valid <= 1'b0;
        drain("vbi line");
    endtask
    always @(rx_cnt) begin
        check("port_data_bus_o", exp_q.size() ? exp_q.pop_front() : 8'hXX, rx_byte);
        if (wide16) check("chroma_ext", ext_q.size() ? ext_q.pop_front() : 8'hXX, ext_o);
    end
    always @(negedge refclk) if (rst_n && qual === 1'b0) check("fill_byte", 0, data_o);
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        did = $random(seed);
        reg_read(`VIOP_REG_CTRL, `VIOP_CTRL_RST);
        reg_read(8'h10, 32'h0);
        reg_write(`VIOP_REG_ANC, {24'h0, did});
        reg_read(`VIOP_REG_ANC, {24'h0, did});
        vid_line(1'b0, 1'b0);
        vid_line(1'b1, 1'b1);
        slow <= 1'b1;
        v_gate <= 1'b0;
        vid_line(1'b0, 1'b1);
        slow <= 1'b0;
        v_gate <= 1'b1;
        reg_write(`VIOP_REG_CTRL, 32'h0000_1233);
        wide16 = 1;
        check("chroma_extension_bus_oe", 1, ext_oe);
        vid_line(1'b0, 1'b1);
        wide16 = 0;
        reg_write(`VIOP_REG_CTRL, `VIOP_CTRL_RST);
        vbi_line(8'h12);
        reg_write(`VIOP_REG_CTRL, 32'h0000_1631);
        rec = 1'b1;
        vbi_line(8'h5A);
        h_gate <= 1'b1;
        repeat (6) @(posedge clk);
        check("horiz_ref_out", 1, h_out);
        check("vert_ref_out", 1, v_out);
        check("gp_out_zero", field, gp0);
        reg_write(`VIOP_REG_REFS, 32'h0000_0004);
        repeat (4) @(posedge clk);
        check("horiz_ref_inverted", 0, h_out);
        h_gate <= 1'b0;
        reg_write(`VIOP_REG_REFS, 32'h0000_0001);
        h_gate <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("horiz_reset_pulse", 1, h_out);
        repeat (20) @(posedge clk);
        check("horiz_pulse_end", 0, h_out);
        check("port_data_bus_oe", 1, data_oe);
        tri_in <= 1'b1;
        repeat (6) @(posedge clk);
        check("port_data_bus_oe", 0, data_oe);
        check("ctrl_outputs_oe", 0, ctrl_oe);
        $display("test refs and tristate done");
        end_sim();
    end
endmodule
